// ===== bench/cppm_host_model.sv
// Host side model issuing register write and read strobes
`timescale 1ns/1ps
`default_nettype none
module cppm_host_model (
   input  wire logic                   clk,
   output var  cppm_pkg::cppm_req_type req,
   input  wire cppm_pkg::cppm_rsp_type rsp
);
   import cppm_pkg::*;
   initial req = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) req <= '{1'b1, 1'b0, a, d};
      @(posedge clk) req <= '0;
   endtask : wr
   // Answer is registered, so it is taken just after the edge that follows the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk) req <= '0;
      #1;
      d = rsp.rdata;
      ok = rsp.rvalid;
   endtask : rd
   // Restart bit written as 1; returning it to 0 is the device's job
   task automatic kick;
      wr(CPPM_ADDR_CHG, 8'h20);
   endtask : kick
   // Pulse mode stays as the caller sets it; turn it off under 2A termination
endmodule : cppm_host_model
`default_nettype wire

// ===== bench/cppm_regs_monitor.sv
// Concurrent checks on the pin, power path and tracking register bank ports
`timescale 1ns/1ps
`default_nettype none
module cppm_regs_monitor (
   input wire logic                    clk,
   input wire logic                    rst,
   input wire cppm_pkg::cppm_req_type  req,
   input wire logic                    watchdog_expired,
   input wire logic                    adapter_plug_in,
   input wire logic                    sync_valid_detect,
   input wire logic                    adc_write_req,
   input wire logic                    charge_enable_pin_disable,
   input wire cppm_pkg::cppm_pins_type status_func,
   input wire cppm_pkg::cppm_pins_type status_pull_oe,
   input wire cppm_pkg::cppm_ctrl_type ctrl,
   input wire logic                    sweep_start,
   input wire logic                    adc_write_accept,
   input wire logic                    watchdog_restart,
   input wire logic                    register_reset
);
   import cppm_pkg::*;
   wire logic path_wr = req.wr && req.addr == CPPM_ADDR_PATH;
   wire logic trk_wr  = req.wr && req.addr == CPPM_ADDR_TRK;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wdog_restore_a: assert property (watchdog_expired |=> ctrl.current_set_pin_enable
      && ctrl.limit_highz_pin_enable && !ctrl.input_load_sink_enable) else $error("watchdog restore");
   adapter_rev_a: assert property (adapter_plug_in |=> !ctrl.reverse_mode_enable)
      else $error("reverse mode kept after adapter insertion");
   reg_reset_a: assert property (path_wr && req.wdata[7] |=> register_reset && ctrl == 8'hD0)
      else $error("register reset did not restore defaults");
   sync_clear_a: assert property (sync_valid_detect && !path_wr
      |=> !ctrl.light_load_pulse_mode_enable) else $error("pulse mode kept after sync");
   sweep_go_a: assert property (trk_wr && req.wdata[7] |=> sweep_start)
      else $error("forced sweep not started");
   trk_field_a: assert property (trk_wr |=> ctrl.full_sweep_interval == $past(req.wdata[2:1])
      && ctrl.power_tracking_enable == $past(req.wdata[0])) else $error("tracking field wrong");
   adc_block_a: assert property (adc_write_req && ctrl.power_tracking_enable
      |=> !adc_write_accept) else $error("adc write passed while tracking");
   wd_kick_a: assert property (req.wr && req.addr == CPPM_ADDR_CHG
      && req.wdata[CPPM_CHG_WD_RESTART] |=> watchdog_restart) else $error("no watchdog restart");
   stat4_hold_a: assert property (!status_func.stat4 && !charge_enable_pin_disable
      |=> !status_pull_oe.stat4) else $error("status four pulled low while pin owned");
endmodule : cppm_regs_monitor

bind cppm_regs cppm_regs_monitor cppm_regs_monitor_i (.clk, .rst, .req, .watchdog_expired,
   .adapter_plug_in, .sync_valid_detect, .adc_write_req, .charge_enable_pin_disable, .status_func,
   .status_pull_oe, .ctrl, .sweep_start, .adc_write_accept, .watchdog_restart, .register_reset);
`default_nettype wire

// ===== bench/cppm_regs_tb_top.sv
// Self-checking bench for the pin, power path and tracking register bank
`timescale 1ns/1ps
`default_nettype none
module cppm_regs_tb_top;
   import cppm_pkg::*;
   typedef struct packed {logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} cppm_row_type;
   logic          clk;
   logic          rst;
   logic          cepd;
   logic [4:0]    evt;
   logic [3:0]    seen;
   logic          seen_clr;
   logic [7:0]    rd;
   cppm_req_type  req;
   cppm_rsp_type  rsp;
   cppm_pins_type sfunc;
   cppm_pins_type oe;
   cppm_ctrl_type ctrl;
   logic          sw_go;
   logic          adc_ok;
   logic          wd_go;
   logic          rr_go;
   int            n_errors;
   int            total_checks;
   int            n_cyc;
   // Short prescaler keeps the minute-scale sweep interval inside the run
   localparam int SEC_SIM   = 4;
   localparam int SWEEP_CYC = CPPM_IVL1_MIN * CPPM_SEC_PER_MIN * SEC_SIM;
   cppm_row_type  rows [10] = '{'{8'h18, 8'hFF, 8'hFF}, '{8'h18, 8'h00, 8'h00},
      '{8'h19, 8'h7F, 8'h61}, '{8'h19, 8'h1E, 8'h00}, '{8'h1A, 8'h1B, 8'h23},
      '{8'h1A, 8'h05, 8'h25}, '{8'h1A, 8'h07, 8'h27}, '{8'h1A, 8'h01, 8'h21},
      '{8'h1A, 8'h00, 8'h20}, '{8'h10, 8'h55, 8'h00}};
   cppm_host_model cppm_host_model_i (.clk(clk), .req(req), .rsp(rsp));
   cppm_regs #(.SEC_CYCLES(SEC_SIM)) cppm_regs_i (.clk(clk), .rst(rst), .req(req), .rsp(rsp),
      .watchdog_expired(evt[4]), .adapter_plug_in(evt[3]), .sync_valid_detect(evt[2]),
      .sweep_complete(evt[1]), .adc_write_req(evt[0]), .charge_enable_pin_disable(cepd),
      .status_func(sfunc), .status_pull_oe(oe), .ctrl(ctrl), .sweep_start(sw_go),
      .adc_write_accept(adc_ok), .watchdog_restart(wd_go), .register_reset(rr_go));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Pulses last one cycle, so they are latched until the bench clears them
   always @(posedge clk) begin
      if (rst || seen_clr) begin
         seen <= '0;
      end else begin
         seen <= seen | {sw_go, adc_ok, wd_go, rr_go};
      end
   end
   task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic ok;
      cppm_host_model_i.rd(a, rd, ok);
      chk("rvalid", {15'h0000, ok}, 16'h0001);
      chk("rdata", {8'h00, rd}, {8'h00, exp});
   endtask : rchk
   task automatic ev(input int i);
      @(posedge clk) evt[i] <= 1'b1;
      @(posedge clk) evt <= '0;
   endtask : ev
   task automatic settle;
      @(posedge clk) seen_clr <= 1'b1;
      @(posedge clk) seen_clr <= 1'b0;
      #1;
   endtask : settle
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end
   initial begin
      rst = 1'b1;
      cepd = 1'b0;
      sfunc = '0;
      evt = '0;
      seen_clr = 1'b0;
      n_errors = 0;
      total_checks = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rchk(CPPM_ADDR_PIN, CPPM_RST_PIN);
      rchk(CPPM_ADDR_PATH, CPPM_RST_PATH);
      rchk(CPPM_ADDR_TRK, CPPM_RST_TRK);
      foreach (rows[i]) begin
         cppm_host_model_i.wr(rows[i].addr, rows[i].data);
         rchk(rows[i].addr, rows[i].exp);
      end
      @(posedge clk) sfunc <= 4'hA;
      cppm_host_model_i.wr(CPPM_ADDR_PIN, 8'h0F);
      settle();
      chk("oe_owned", {12'h000, oe}, 16'h000A);
      @(posedge clk) cepd <= 1'b1;
      cppm_host_model_i.wr(CPPM_ADDR_PIN, 8'h3F);
      settle();
      chk("oe_forced", {12'h000, oe}, 16'h000F);
      cppm_host_model_i.wr(CPPM_ADDR_PIN, 8'h30);
      // Pulse mode left on so the watchdog is seen to clear only its own bits
      cppm_host_model_i.wr(CPPM_ADDR_PATH, 8'h61);
      ev(4);
      rchk(CPPM_ADDR_PIN, 8'hF0);
      rchk(CPPM_ADDR_PATH, 8'h20);
      cppm_host_model_i.wr(CPPM_ADDR_PATH, 8'h61);
      ev(3);
      rchk(CPPM_ADDR_PATH, 8'h60);
      ev(2);
      rchk(CPPM_ADDR_PATH, 8'h40);
      cppm_host_model_i.wr(CPPM_ADDR_PATH, 8'h21);
      rchk(CPPM_ADDR_PATH, 8'h21);
      settle();
      cppm_host_model_i.wr(CPPM_ADDR_TRK, 8'h81);
      rchk(CPPM_ADDR_TRK, 8'hA1);
      chk("sweep_start", {15'h0000, seen[3]}, 16'h0001);
      ev(1);
      rchk(CPPM_ADDR_TRK, 8'h21);
      settle();
      ev(0);
      @(posedge clk);
      #1 chk("adc_blocked", {15'h0000, seen[2]}, 16'h0000);
      cppm_host_model_i.wr(CPPM_ADDR_TRK, 8'h00);
      ev(0);
      @(posedge clk);
      #1 chk("adc_passed", {15'h0000, seen[2]}, 16'h0001);
      settle();
      cppm_host_model_i.kick();
      @(posedge clk);
      #1 chk("wd_restart", {15'h0000, seen[1]}, 16'h0001);
      // Tracking on with the ten-minute interval; count cycles to the periodic sweep
      cppm_host_model_i.wr(CPPM_ADDR_TRK, 8'h03);
      for (n_cyc = 1; n_cyc <= 3000; n_cyc++) begin
         @(posedge clk);
         #1;
         if (sw_go === 1'b1) begin
            break;
         end
      end
      chk("sweep_period", 16'(n_cyc), 16'(SWEEP_CYC));
      cppm_host_model_i.wr(CPPM_ADDR_PATH, 8'h80);
      @(posedge clk);
      #1 chk("reg_reset", {15'h0000, seen[0]}, 16'h0001);
      rchk(CPPM_ADDR_PIN, CPPM_RST_PIN);
      rchk(CPPM_ADDR_PATH, CPPM_RST_PATH);
      rchk(CPPM_ADDR_TRK, CPPM_RST_TRK);
      // Mid-run reset must give the same defaults as the register reset
      cppm_host_model_i.wr(CPPM_ADDR_PIN, 8'h3F);
      cppm_host_model_i.wr(CPPM_ADDR_PATH, 8'h41);
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rchk(CPPM_ADDR_PIN, CPPM_RST_PIN);
      rchk(CPPM_ADDR_PATH, CPPM_RST_PATH);
      report_and_stop();
   end
endmodule : cppm_regs_tb_top
`default_nettype wire

// ===== design/cppm_pkg.sv
// Constants and carrier types for the pin, power path and tracking register bank
package cppm_pkg;

   // Register addresses
   localparam logic [7:0] CPPM_ADDR_PIN   = 8'h18;
   localparam logic [7:0] CPPM_ADDR_PATH  = 8'h19;
   localparam logic [7:0] CPPM_ADDR_TRK   = 8'h1A;
   // Charger control register owned elsewhere; only its restart bit is watched
   localparam logic [7:0] CPPM_ADDR_CHG   = 8'h17;

   // Reset values
   localparam logic [7:0] CPPM_RST_PIN    = 8'hC0;
   localparam logic [7:0] CPPM_RST_PATH   = 8'h20;
   localparam logic [7:0] CPPM_RST_TRK    = 8'h20;

   // Pin function control fields
   localparam int CPPM_PIN_CUR_SET_EN     = 7;
   localparam int CPPM_PIN_LIM_HIZ_EN     = 6;
   localparam int CPPM_PIN_PG_DIS         = 5;
   localparam int CPPM_PIN_STAT_DIS       = 4;
   localparam int CPPM_PIN_FORCE4         = 3;
   localparam int CPPM_PIN_FORCE3         = 2;
   localparam int CPPM_PIN_FORCE2         = 1;
   localparam int CPPM_PIN_FORCE1         = 0;

   // Power path fields; bits 4:1 reserved
   localparam int CPPM_PATH_REG_RESET     = 7;
   localparam int CPPM_PATH_SINK_EN       = 6;
   localparam int CPPM_PATH_PULSE_EN      = 5;
   localparam int CPPM_PATH_REV_EN        = 0;
   localparam logic [7:0] CPPM_PATH_WMASK = 8'h61;

   // Tracking fields; bits 6:5 read back their reset value, 4:3 reserved
   localparam int CPPM_TRK_FORCE_SWEEP    = 7;
   localparam int CPPM_TRK_IVL_HI         = 2;
   localparam int CPPM_TRK_IVL_LO         = 1;
   localparam int CPPM_TRK_EN             = 0;
   localparam logic [7:0] CPPM_TRK_WMASK  = 8'h87;
   localparam logic [7:0] CPPM_TRK_FIXED  = 8'h20;

   // Charger control restart bit
   localparam int CPPM_CHG_WD_RESTART     = 5;

   // Timing
   localparam int CPPM_CLK_HZ             = 50_000_000;
   localparam int CPPM_SEC_CYCLES         = CPPM_CLK_HZ;
   localparam int CPPM_SEC_W              = 26;
   localparam int CPPM_IVL_W              = 11;
   localparam int CPPM_IVL0_MIN           = 3;
   localparam int CPPM_IVL1_MIN           = 10;
   localparam int CPPM_IVL2_MIN           = 15;
   localparam int CPPM_IVL3_MIN           = 20;
   localparam int CPPM_SEC_PER_MIN        = 60;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cppm_req_type;

   typedef struct packed {
      logic       rvalid;
      logic [7:0] rdata;
   } cppm_rsp_type;

   // Normal pull-low requests of each shared status pin
   typedef struct packed {
      logic stat4;
      logic stat3;
      logic status_two_pin;
      logic status_one_pin;
   } cppm_pins_type;

   typedef struct packed {
      logic       current_set_pin_enable;
      logic       limit_highz_pin_enable;
      logic       input_load_sink_enable;
      logic       light_load_pulse_mode_enable;
      logic       reverse_mode_enable;
      logic       power_tracking_enable;
      logic [1:0] full_sweep_interval;
   } cppm_ctrl_type;

endpackage : cppm_pkg

// ===== design/cppm_regs.sv
// Pin, power path and power point tracking control registers with pin override logic
`timescale 1ns/1ps
`default_nettype none

module cppm_regs #(
   parameter int SEC_CYCLES = cppm_pkg::CPPM_SEC_CYCLES
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire cppm_pkg::cppm_req_type req,
   output var  cppm_pkg::cppm_rsp_type rsp,
   input  wire logic                   watchdog_expired,
   input  wire logic                   adapter_plug_in,
   input  wire logic                   sync_valid_detect,
   input  wire logic                   sweep_complete,
   input  wire logic                   adc_write_req,
   input  wire logic                   charge_enable_pin_disable,
   input  wire cppm_pkg::cppm_pins_type status_func,
   output var  cppm_pkg::cppm_pins_type status_pull_oe,
   output var  cppm_pkg::cppm_ctrl_type ctrl,
   output logic                        sweep_start,
   output logic                        adc_write_accept,
   output logic                        watchdog_restart,
   output logic                        register_reset
);
   import cppm_pkg::*;

   typedef struct packed {
      logic [7:0]            pin;
      logic [7:0]            path;
      logic [7:0]            trk;
      cppm_rsp_type          rsp;
      logic [CPPM_SEC_W-1:0] sec_cnt;
      logic [CPPM_IVL_W-1:0] ivl_cnt;
      logic                  sweep;
      logic                  adc_ok;
      logic                  watchdog_restart_bit;
      logic                  reg_rst;
      cppm_pins_type         oe;
   } cppm_state_type;

   localparam logic [CPPM_SEC_W-1:0] SEC_LAST = CPPM_SEC_W'(SEC_CYCLES - 1);

   cppm_state_type state_r;
   cppm_state_type state_nxt;

   function automatic logic [CPPM_IVL_W-1:0] interval_sec(input logic [1:0] sel);
      int mins;
      unique case (sel)
         2'b00: mins = CPPM_IVL0_MIN;
         2'b01: mins = CPPM_IVL1_MIN;
         2'b10: mins = CPPM_IVL2_MIN;
         2'b11: mins = CPPM_IVL3_MIN;
      endcase
      return CPPM_IVL_W'(mins * CPPM_SEC_PER_MIN);
   endfunction : interval_sec

   function automatic logic pin_drive(input logic func_dis, input logic force_low,
                                      input logic normal);
      // Override only takes hold once the pin's own function is off
      return func_dis ? force_low : normal;
   endfunction : pin_drive

   logic wr_pin;
   logic wr_path;
   logic wr_trk;
   logic wr_chg;
   logic do_reg_reset;
   logic force_write;
   logic ivl_hit;

   always_comb begin
      state_nxt = state_r;
      wr_pin    = req.wr && (req.addr == CPPM_ADDR_PIN);
      wr_path   = req.wr && (req.addr == CPPM_ADDR_PATH);
      wr_trk    = req.wr && (req.addr == CPPM_ADDR_TRK);
      wr_chg    = req.wr && (req.addr == CPPM_ADDR_CHG);
      do_reg_reset = wr_path && req.wdata[CPPM_PATH_REG_RESET];
      force_write  = wr_trk && req.wdata[CPPM_TRK_FORCE_SWEEP];
      ivl_hit      = 1'b0;

      state_nxt.reg_rst = do_reg_reset;
      state_nxt.watchdog_restart_bit  = wr_chg && req.wdata[CPPM_CHG_WD_RESTART];
      state_nxt.sweep   = 1'b0;

      if (do_reg_reset) begin
         // Whole bank to defaults; the reset bit itself never reads back as 1
         state_nxt.pin     = CPPM_RST_PIN;
         state_nxt.path    = CPPM_RST_PATH;
         state_nxt.trk     = CPPM_RST_TRK;
         state_nxt.sec_cnt = '0;
         state_nxt.ivl_cnt = '0;
      end else begin
         if (wr_pin) begin
            state_nxt.pin = req.wdata;
         end
         if (wr_path) begin
            state_nxt.path = req.wdata & CPPM_PATH_WMASK;
         end
         if (wr_trk) begin
            // A pending sweep keeps its bit set until it completes
            state_nxt.trk = (req.wdata & CPPM_TRK_WMASK) | CPPM_TRK_FIXED;
            state_nxt.trk[CPPM_TRK_FORCE_SWEEP] = req.wdata[CPPM_TRK_FORCE_SWEEP] |
                                                  state_r.trk[CPPM_TRK_FORCE_SWEEP];
         end

         // Sync detection clears pulse mode unless the host rewrites it now
         if (sync_valid_detect && !wr_path) begin
            state_nxt.path[CPPM_PATH_PULSE_EN] = 1'b0;
         end

         if (watchdog_expired) begin
            state_nxt.pin[CPPM_PIN_CUR_SET_EN] = 1'b1;
            state_nxt.pin[CPPM_PIN_LIM_HIZ_EN] = 1'b1;
            state_nxt.path[CPPM_PATH_SINK_EN]  = 1'b0;
            state_nxt.path[CPPM_PATH_REV_EN]   = 1'b0;
         end
         if (adapter_plug_in) begin
            state_nxt.path[CPPM_PATH_REV_EN]   = 1'b0;
         end

         // Completion clears the force bit; a new force write in the same cycle wins
         if (sweep_complete && !force_write) begin
            state_nxt.trk[CPPM_TRK_FORCE_SWEEP] = 1'b0;
         end

         // Periodic sweep timer, one second prescaler then interval count
         if (force_write) begin
            state_nxt.sec_cnt = '0;
            state_nxt.ivl_cnt = '0;
            state_nxt.sweep   = 1'b1;
         end else if (!state_r.trk[CPPM_TRK_EN]) begin
            state_nxt.sec_cnt = '0;
            state_nxt.ivl_cnt = '0;
         end else if (state_r.sec_cnt == SEC_LAST) begin
            state_nxt.sec_cnt = '0;
            ivl_hit = (state_r.ivl_cnt + 1'b1) >=
                      interval_sec(state_r.trk[CPPM_TRK_IVL_HI:CPPM_TRK_IVL_LO]);
            if (ivl_hit) begin
               state_nxt.ivl_cnt = '0;
               state_nxt.sweep   = 1'b1;
            end else begin
               state_nxt.ivl_cnt = state_r.ivl_cnt + 1'b1;
            end
         end else begin
            state_nxt.sec_cnt = state_r.sec_cnt + 1'b1;
         end
      end

      // Device owns the ADC while tracking runs
      state_nxt.adc_ok = adc_write_req && !state_r.trk[CPPM_TRK_EN];

      state_nxt.oe.stat4 = pin_drive(charge_enable_pin_disable,
                                     state_r.pin[CPPM_PIN_FORCE4],
                                     status_func.stat4);
      state_nxt.oe.stat3 = pin_drive(state_r.pin[CPPM_PIN_PG_DIS],
                                     state_r.pin[CPPM_PIN_FORCE3],
                                     status_func.stat3);
      state_nxt.oe.status_two_pin = pin_drive(state_r.pin[CPPM_PIN_STAT_DIS],
                                     state_r.pin[CPPM_PIN_FORCE2],
                                     status_func.status_two_pin);
      state_nxt.oe.status_one_pin = pin_drive(state_r.pin[CPPM_PIN_STAT_DIS],
                                     state_r.pin[CPPM_PIN_FORCE1],
                                     status_func.status_one_pin);

      // Reads return the value before any write in the same cycle
      state_nxt.rsp.rvalid = req.rd;
      if (req.rd) begin
         unique case (req.addr)
            CPPM_ADDR_PIN:  state_nxt.rsp.rdata = state_r.pin;
            CPPM_ADDR_PATH: state_nxt.rsp.rdata = state_r.path;
            CPPM_ADDR_TRK:  state_nxt.rsp.rdata = state_r.trk;
            default:        state_nxt.rsp.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r         <= '0;
         state_r.pin     <= CPPM_RST_PIN;
         state_r.path    <= CPPM_RST_PATH;
         state_r.trk     <= CPPM_RST_TRK;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign rsp              = state_r.rsp;
   assign status_pull_oe   = state_r.oe;
   assign sweep_start      = state_r.sweep;
   assign adc_write_accept = state_r.adc_ok;
   assign watchdog_restart = state_r.watchdog_restart_bit;
   assign register_reset   = state_r.reg_rst;

   assign ctrl.current_set_pin_enable       = state_r.pin[CPPM_PIN_CUR_SET_EN];
   assign ctrl.limit_highz_pin_enable       = state_r.pin[CPPM_PIN_LIM_HIZ_EN];
   assign ctrl.input_load_sink_enable       = state_r.path[CPPM_PATH_SINK_EN];
   assign ctrl.light_load_pulse_mode_enable = state_r.path[CPPM_PATH_PULSE_EN];
   assign ctrl.reverse_mode_enable          = state_r.path[CPPM_PATH_REV_EN];
   assign ctrl.power_tracking_enable        = state_r.trk[CPPM_TRK_EN];
   assign ctrl.full_sweep_interval          = state_r.trk[CPPM_TRK_IVL_HI:CPPM_TRK_IVL_LO];

endmodule : cppm_regs

`default_nettype wire
